// File: rtl/ufb_pkg.sv
// Shared constants, types and decode functions for the secondary serial port
package ufb_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_BAUD_CTRL = 8'hac;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hb4;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hb5;
  localparam logic [7:0] ADDR_CTRL      = 8'hd2;
  localparam logic [7:0] ADDR_DATA      = 8'hd3;
  localparam logic [7:0] ADDR_MODE      = 8'he5;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h0c;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  // Control register bit positions
  localparam int CTRL_OVR  = 7;
  localparam int CTRL_PERR = 6;
  localparam int CTRL_THRE = 5;
  localparam int CTRL_REN  = 4;
  localparam int CTRL_TBX  = 3;
  localparam int CTRL_RBX  = 2;
  localparam int CTRL_TI   = 1;
  localparam int CTRL_RI   = 0;
  // Parity type codes
  localparam logic [1:0] PAR_ODD   = 2'h0;
  localparam logic [1:0] PAR_EVEN  = 2'h1;
  localparam logic [1:0] PAR_MARK  = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  // Prescaler divide counts per select code
  localparam logic [5:0] DIV_SEL0 = 6'h0c;
  localparam logic [5:0] DIV_SEL1 = 6'h04;
  localparam logic [5:0] DIV_SEL2 = 6'h30;
  localparam logic [5:0] DIV_SEL3 = 6'h01;
  // Stop length in half bit times
  localparam logic [4:0] STOP_SHORT = 5'h02;
  localparam logic [4:0] STOP_MID   = 5'h03;
  localparam logic [4:0] STOP_LONG  = 5'h04;
  // Fewest data bits in a character
  localparam logic [3:0] DATA_MIN = 4'h5;
  // Receive queue depth
  localparam int RX_DEPTH = 3;

  // Frame format register layout
  typedef struct packed {
    logic       multiproc_filter_enable;
    logic [1:0] parity_type_sel;
    logic       parity_enable;
    logic [1:0] data_length_sel;
    logic       extra_bit_enable;
    logic       stop_length_sel;
  } ufb_mode_type;

  // Baud generator control layout
  typedef struct packed {
    logic       rsv_hi;
    logic       baud_gen_run;
    logic [3:0] rsv_lo;
    logic [1:0] baud_prescale_sel;
  } ufb_baud_type;

  // One queued received character
  typedef struct packed {
    logic       extra;
    logic [7:0] data;
  } ufb_rx_entry_type;

  // Data bit count from the length code
  function automatic logic [3:0] data_bits(input logic [1:0] sel);
    data_bits = DATA_MIN + {2'h0, sel};
  endfunction

  // Parity bit for the low n bits of d
  function automatic logic parity_bit(input logic [7:0] d, input logic [3:0] n,
                                      input logic [1:0] t);
    logic [7:0] m;
    m = d & ~(8'hff << n);
    case (t)
      PAR_ODD:  parity_bit = ~^m;
      PAR_EVEN: parity_bit = ^m;
      PAR_MARK: parity_bit = 1'b1;
      default:  parity_bit = 1'b0;
    endcase
  endfunction
endpackage

// File: rtl/ufb_rx_fifo.sv
// Small flip-flop queue with valid and ready on both sides
`timescale 1ns/1ns
module ufb_rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 3,
  parameter int CW    = 2
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  output logic [CW-1:0]         count_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage cells
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [CW-1:0]    wr_reg, wr_next;  // Write index
  logic [CW-1:0]    rd_reg, rd_next;  // Read index
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             push, pop;

  // Honest full and empty straight from the count
  assign in_ready_out  = cnt_reg != CW'(DEPTH);
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out  = mem_reg[rd_reg];
  assign count_out     = cnt_reg;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_ready_in & out_valid_out;

  // Next pointers, count and storage
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_in;
      wr_next = (wr_reg == CW'(DEPTH - 1)) ? '0 : wr_reg + CW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == CW'(DEPTH - 1)) ? '0 : rd_reg + CW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + CW'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CW'(1);
    end
  end

  // Register the queue state
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// File: rtl/ufb_serial_port.sv
// Secondary serial port: registers, baud generator, transmitter, receiver
//
// Function
// receive flag needs stop, and extra if filtering
// filtering only without parity and with extra
// parity type odd, even, mark, space
// parity enable generates and checks parity
// length code gives five to eight bits
// stop one, two, or one and half
// extra bit appended after data when enabled
// data write goes to holding register
// holding byte moves when shifter free
// data read pops oldest queued byte
// receive queue holds three bytes
// receive flag stays while more bytes wait
// generator enable gates whole port
// prescaler divides by 12, 4, 48, 1
// reserved control bits written and read zero
// register holds reload high byte
// register holds reload low byte
// parity mismatch sets sticky parity error
// extra receive bit or first stop level
// master marks address bytes with extra one
// reload counter overflows give bit timebase
// start zero, data LSB first, extra, stops
`timescale 1ns/1ns
module ufb_serial_port
  import ufb_pkg::*;
#(
  parameter int RX_FIFO_DEPTH = RX_DEPTH
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Special function register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic [7:0]      sfr_rdata_out,
  // Serial line
  input  wire logic       rx_line_in,
  output logic            tx_line_out
);
  typedef enum logic {TX_IDLE, TX_SHIFT} ufb_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ufb_rx_state_type;

  // Software visible state
  ufb_mode_type mode_reg, mode_next;
  ufb_baud_type baud_reg, baud_next;
  logic [7:0]   rl_lo_reg, rl_lo_next;    // Reload low byte
  logic [7:0]   rl_hi_reg, rl_hi_next;    // Reload high byte
  logic [7:0]   hold_reg, hold_next;      // Transmit holding byte
  logic         hold_v_reg, hold_v_next;
  logic         ren_reg, ren_next;        // Receiver enable
  logic         tbx_reg, tbx_next;        // extra_tx_bit
  logic         ovr_reg, ovr_next;
  logic         perr_reg, perr_next;      // parity_error_flag
  logic         ti_reg, ti_next;
  logic         ri_reg, ri_next;          // receive_flag
  logic [7:0]   rdata_reg, rdata_next;
  // Baud generator
  logic [5:0]   pre_reg, pre_next;
  logic [5:0]   div;
  logic [15:0]  tmr_reg, tmr_next;
  logic         half_reg, half_next;      // Half bit time tick
  logic         run;
  // Line input synchroniser
  logic [2:0]   sync_reg, sync_next;
  logic         lvl_reg, lvl_next;
  // Transmitter
  ufb_tx_state_type tx_st_reg, tx_st_next;
  logic [10:0]  txf_reg, txf_next;        // Frame, bit 0 on the line
  logic [4:0]   txh_reg, txh_next;        // Half bits left
  logic [4:0]   txs_reg, txs_next;        // Stop length in halves
  logic         txp_reg, txp_next;        // Second half of a bit
  logic         txo_reg, txo_next;
  logic         tx_load, tx_stop_evt;
  // Receiver
  ufb_rx_state_type rx_st_reg, rx_st_next;
  logic [9:0]   rxs_reg, rxs_next;
  logic [3:0]   rxl_reg, rxl_next;        // Samples left
  logic         rxw_reg, rxw_next;        // One more half to wait
  logic         rx_try, rx_ovr, rx_perr;
  ufb_rx_entry_type rx_in, rx_head;
  logic         rx_ready, rx_valid, rx_pop;
  logic [1:0]   rx_cnt;
  // Shared format decode
  logic [3:0]   n_bits;
  logic         xb, mce_eff;

  assign run     = baud_reg.baud_gen_run;
  assign n_bits  = data_bits(mode_reg.data_length_sel);
  assign xb      = mode_reg.parity_enable | mode_reg.extra_bit_enable;
  // Filtering is meaningless while the extra slot carries parity
  assign mce_eff = mode_reg.multiproc_filter_enable & mode_reg.extra_bit_enable
                   & ~mode_reg.parity_enable;
  assign rx_pop  = sfr_rd_in & (sfr_addr_in == ADDR_DATA);

  // Register writes, sticky flags and read data
  always_comb begin
    mode_next  = mode_reg;
    baud_next  = baud_reg;
    rl_lo_next = rl_lo_reg;
    rl_hi_next = rl_hi_reg;
    hold_next  = hold_reg;
    hold_v_next = hold_v_reg & ~tx_load;
    ren_next   = ren_reg;
    tbx_next   = tbx_reg;
    // Hardware sets win over a same cycle clear
    ovr_next   = ovr_reg | rx_ovr;
    perr_next  = perr_reg | rx_perr;
    ti_next    = ti_reg | tx_stop_evt;
    ri_next    = ri_reg | rx_try | (rx_cnt > 2'h1);
    rdata_next = rdata_reg;
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        ADDR_MODE: mode_next = sfr_wdata_in;
        ADDR_BAUD_CTRL: begin
          // Reserved bits are never stored, so they read zero
          baud_next = ZERO_RESET;
          baud_next.baud_gen_run = sfr_wdata_in[6];
          baud_next.baud_prescale_sel = sfr_wdata_in[1:0];
        end
        ADDR_RELOAD_LO: rl_lo_next = sfr_wdata_in;
        ADDR_RELOAD_HI: rl_hi_next = sfr_wdata_in;
        ADDR_CTRL: begin
          ren_next  = sfr_wdata_in[CTRL_REN];
          tbx_next  = sfr_wdata_in[CTRL_TBX];
          ovr_next  = sfr_wdata_in[CTRL_OVR] | rx_ovr;
          perr_next = sfr_wdata_in[CTRL_PERR] | rx_perr;
          ti_next   = sfr_wdata_in[CTRL_TI] | tx_stop_evt;
          ri_next   = sfr_wdata_in[CTRL_RI] | rx_try | (rx_cnt > 2'h1);
        end
        ADDR_DATA: begin
          // A write while the holder is full is dropped
          if (!hold_v_reg) begin
            hold_next   = sfr_wdata_in;
            hold_v_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        ADDR_MODE:      rdata_next = mode_reg;
        ADDR_BAUD_CTRL: rdata_next = baud_reg;
        ADDR_RELOAD_LO: rdata_next = rl_lo_reg;
        ADDR_RELOAD_HI: rdata_next = rl_hi_reg;
        ADDR_DATA:      rdata_next = rx_head.data;
        ADDR_CTRL: rdata_next = {ovr_reg, perr_reg, ~hold_v_reg, ren_reg,
                                 tbx_reg, rx_head.extra, ti_reg, ri_reg};
        default:        rdata_next = ZERO_RESET;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg  <= MODE_RESET;
      baud_reg  <= ZERO_RESET;
      rl_lo_reg <= ZERO_RESET;
      rl_hi_reg <= ZERO_RESET;
      hold_reg  <= ZERO_RESET;
      hold_v_reg <= 1'b0;
      ren_reg   <= 1'b0;
      tbx_reg   <= 1'b0;
      ovr_reg   <= 1'b0;
      perr_reg  <= 1'b0;
      ti_reg    <= 1'b0;
      ri_reg    <= 1'b0;
      rdata_reg <= ZERO_RESET;
    end else begin
      mode_reg  <= mode_next;
      baud_reg  <= baud_next;
      rl_lo_reg <= rl_lo_next;
      rl_hi_reg <= rl_hi_next;
      hold_reg  <= hold_next;
      hold_v_reg <= hold_v_next;
      ren_reg   <= ren_next;
      tbx_reg   <= tbx_next;
      ovr_reg   <= ovr_next;
      perr_reg  <= perr_next;
      ti_reg    <= ti_next;
      ri_reg    <= ri_next;
      rdata_reg <= rdata_next;
    end
  end

  // Prescaler and reload timer; each overflow is half a bit time
  always_comb begin
    case (baud_reg.baud_prescale_sel)
      2'h0:    div = DIV_SEL0;
      2'h1:    div = DIV_SEL1;
      2'h2:    div = DIV_SEL2;
      default: div = DIV_SEL3;
    endcase
    pre_next  = pre_reg;
    tmr_next  = tmr_reg;
    half_next = 1'b0;
    if (!run) begin
      pre_next = '0;
      tmr_next = {rl_hi_reg, rl_lo_reg};
    end else if (pre_reg >= div - 6'h01) begin
      pre_next = '0;
      if (tmr_reg == 16'hffff) begin
        tmr_next  = {rl_hi_reg, rl_lo_reg};
        half_next = 1'b1;
      end else begin
        tmr_next = tmr_reg + 16'h0001;
      end
    end else begin
      pre_next = pre_reg + 6'h01;
    end
    // Three stage pin sampler; a level counts once stages two and three agree
    sync_next = {sync_reg[1:0], rx_line_in};
    lvl_next  = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : lvl_reg;
  end

  // Timebase and sampler registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_reg  <= '0;
      tmr_reg  <= '0;
      half_reg <= 1'b0;
      sync_reg <= 3'h7;
      lvl_reg  <= 1'b1;
    end else begin
      pre_reg  <= pre_next;
      tmr_reg  <= tmr_next;
      half_reg <= half_next;
      sync_reg <= sync_next;
      lvl_reg  <= lvl_next;
    end
  end

  // Transmitter: whole frame loaded, shifted every second half tick
  always_comb begin
    tx_st_next  = tx_st_reg;
    txf_next    = txf_reg;
    txh_next    = txh_reg;
    txs_next    = txs_reg;
    txp_next    = txp_reg;
    tx_load     = 1'b0;
    tx_stop_evt = 1'b0;
    case (tx_st_reg)
      TX_IDLE: begin
        if (run && hold_v_reg) begin
          tx_load    = 1'b1;
          tx_st_next = TX_SHIFT;
          txp_next   = 1'b0;
          txf_next[0] = 1'b0;
          for (int i = 0; i < 10; i++) begin
            if (i < int'(n_bits)) begin
              txf_next[i+1] = hold_reg[i%8];
            end else if (i == int'(n_bits) && xb) begin
              // Parity takes the extra slot when enabled
              txf_next[i+1] = mode_reg.parity_enable ?
                parity_bit(hold_reg, n_bits, mode_reg.parity_type_sel) : tbx_reg;
            end else begin
              txf_next[i+1] = 1'b1;
            end
          end
          if (!mode_reg.stop_length_sel) begin
            txs_next = STOP_SHORT;
          end else if (n_bits == DATA_MIN) begin
            txs_next = STOP_MID;
          end else begin
            txs_next = STOP_LONG;
          end
          txh_next = {(n_bits + 4'h1 + {3'h0, xb}), 1'b0} + txs_next;
        end
      end
      TX_SHIFT: begin
        if (!run) begin
          tx_st_next = TX_IDLE;
        end else if (half_reg) begin
          txh_next = txh_reg - 5'h01;
          txp_next = ~txp_reg;
          if (txp_reg) begin
            txf_next = {1'b1, txf_reg[10:1]};
          end
          if (txh_next == txs_reg) begin
            tx_stop_evt = 1'b1;
          end
          if (txh_reg == 5'h01) begin
            tx_st_next = TX_IDLE;
          end
        end
      end
      default: tx_st_next = TX_IDLE;
    endcase
    txo_next = (tx_st_next == TX_SHIFT) ? txf_next[0] : 1'b1;
  end

  // Transmitter registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_reg <= TX_IDLE;
      txf_reg   <= '1;
      txh_reg   <= '0;
      txs_reg   <= STOP_SHORT;
      txp_reg   <= 1'b0;
      txo_reg   <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      txf_reg   <= txf_next;
      txh_reg   <= txh_next;
      txs_reg   <= txs_next;
      txp_reg   <= txp_next;
      txo_reg   <= txo_next;
    end
  end

  // Receiver: start check at half a bit, then one sample per bit
  always_comb begin
    logic [9:0] fr;
    logic [3:0] total;
    logic       ext, stp;
    fr    = '0;
    ext   = 1'b0;
    stp   = 1'b0;
    total = n_bits + 4'h1 + {3'h0, xb};
    rx_st_next = rx_st_reg;
    rxs_next = rxs_reg;
    rxl_next = rxl_reg;
    rxw_next = rxw_reg;
    rx_try   = 1'b0;
    rx_perr  = 1'b0;
    rx_in    = '0;
    case (rx_st_reg)
      RX_IDLE: begin
        if (run && ren_reg && !lvl_reg) begin
          rx_st_next = RX_START;
        end
      end
      RX_START: begin
        if (half_reg) begin
          rx_st_next = lvl_reg ? RX_IDLE : RX_BITS;
          rxw_next = 1'b1;
          rxl_next = total;
        end
      end
      RX_BITS: begin
        if (half_reg) begin
          rxw_next = ~rxw_reg;
          if (!rxw_reg) begin
            rxs_next = {lvl_reg, rxs_reg[9:1]};
            rxl_next = rxl_reg - 4'h1;
            if (rxl_reg == 4'h1) begin
              rx_st_next = RX_IDLE;
              fr  = rxs_next >> (4'ha - total);
              ext = fr[n_bits];
              stp = lvl_reg;
              rx_in.data  = fr[7:0] & ~(8'hff << n_bits);
              rx_in.extra = mode_reg.extra_bit_enable ? ext : stp;
              // Address bytes carry extra one when filtering
              rx_try = stp & (~mce_eff | ext);
              rx_perr = rx_try & mode_reg.parity_enable &
                (ext != parity_bit(rx_in.data, n_bits, mode_reg.parity_type_sel));
            end
          end
        end
      end
      default: rx_st_next = RX_IDLE;
    endcase
    if (!run || !ren_reg) begin
      rx_st_next = RX_IDLE;
    end
  end
  assign rx_ovr = rx_try & ~rx_ready;

  // Receiver registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_reg <= RX_IDLE;
      rxs_reg   <= '0;
      rxl_reg   <= '0;
      rxw_reg   <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rxs_reg   <= rxs_next;
      rxl_reg   <= rxl_next;
      rxw_reg   <= rxw_next;
    end
  end

  // Receive queue; a full queue drops the new byte and flags overrun
  ufb_rx_fifo #(.WIDTH(9), .DEPTH(RX_FIFO_DEPTH), .CW(2)) u_rx_fifo (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .in_valid_in  (rx_try),
    .in_ready_out (rx_ready),
    .in_data_in   (rx_in),
    .out_valid_out(rx_valid),
    .out_ready_in (rx_pop),
    .out_data_out (rx_head),
    .count_out    (rx_cnt)
  );

  assign sfr_rdata_out = rdata_reg;
  assign tx_line_out   = txo_reg;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_stop_idle;
    !run |=> tx_line_out;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("line not idle when stopped");
  property p_rsv_zero;
    sfr_rd_in && sfr_addr_in == ADDR_BAUD_CTRL |=> sfr_rdata_out[7] == 1'b0 && sfr_rdata_out[5:2] == 4'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
  property p_depth;
    rx_try && rx_cnt == 2'h3 && !rx_pop |=> rx_cnt == 2'h3 && ovr_reg;
  endproperty
  a_depth: assert property (p_depth) else $error("fourth byte not refused");
  property p_ri_hold;
    rx_cnt > 2'h1 |=> ri_reg;
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("flag cleared with bytes waiting");
  sequence s_ready_to_load;
    run && hold_v_reg && tx_st_reg == TX_IDLE;
  endsequence
  property p_load;
    s_ready_to_load |=> !hold_v_reg ##0 tx_st_reg == TX_SHIFT;
  endproperty
  a_load: assert property (p_load) else $error("held byte not moved");
  property p_start_bit;
    $rose(tx_st_reg == TX_SHIFT) |-> !tx_line_out;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("frame did not start low");
  property p_write_hold;
    sfr_wr_in && sfr_addr_in == ADDR_DATA && !hold_v_reg |=> hold_v_reg && hold_reg == $past(sfr_wdata_in);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write not held");
  property p_pop;
    rx_pop && rx_valid && !rx_try |=> rx_cnt == $past(rx_cnt) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not remove byte");
  property p_perr;
    rx_perr |=> perr_reg;
  endproperty
  a_perr: assert property (p_perr) else $error("parity error lost");
endmodule

// File: tb/ufb_line_peer.sv
// Far-end serial peer model: sends frames and captures frames
`timescale 1ns/1ns
module ufb_line_peer #(
  parameter int BIT_NS = 40  // Bit time at prescale /1, reload 0xfffe
) (
  // Serial line
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  // Line rests high, as a pulled-up line does
  initial rx_line_out = 1'b1;

  // Start low, n bits LSB first, then stop and idle high
  task automatic send(input logic [10:0] bits, input int n);
    #2;  // Keep line edges off the clock edge
    rx_line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      rx_line_out = bits[i];
      #(BIT_NS);
    end
    rx_line_out = 1'b1;
    #(2 * BIT_NS);
  endtask

  // First sample at 1.25 bits, so a start cut short still lands in bit 0
  task automatic grab(input int n, output logic [11:0] bits);
    bits = '0;
    @(negedge tx_line_in);
    #(BIT_NS + BIT_NS / 4 + 1);
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        #(BIT_NS);
      end
      bits[i] = tx_line_in;
    end
  endtask
endmodule

// File: tb/tb_top.sv
// Register-level testbench for the secondary serial port
`timescale 1ns/1ns
module tb_top
  import ufb_pkg::*;
;
  logic       clock_in  = 1'b0;  // System clock
  logic       rst_n_in  = 1'b0;  // Reset, active low
  logic [7:0] sfr_addr  = 8'h00; // Register address
  logic       sfr_wr    = 1'b0;  // Write strobe
  logic       sfr_rd    = 1'b0;  // Read strobe
  logic [7:0] sfr_wdata = 8'h00; // Write data
  logic [7:0] sfr_rdata;         // Read data
  wire        line_tx;           // Port to peer
  wire        line_rx;           // Peer to port
  int         err_total   = 0;   // Mismatches
  int         check_count = 0;   // Comparisons
  int         cyc         = 0;   // Cycle count for the hang guard
  logic [11:0] g1;               // Captured frames
  logic [11:0] g2;
  logic [7:0] v;                 // Read value
  logic [7:0] m;                 // Masked data
  logic       p;                 // Expected parity
  logic       lo;                // Line seen low
  int         dv;                // Expected prescale divide
  int         lowc;              // Cycles seen low

  ufb_serial_port dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr),
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
    .rx_line_in(line_rx), .tx_line_out(line_tx));
  ufb_line_peer peer_u (.tx_line_in(line_tx), .rx_line_out(line_rx));

  // 100 MHz clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe, then a quiet edge so calls in a row never clash
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock_in);
    sfr_wr <= 1'b0;
    @(posedge clock_in);
  endtask

  // Read data settles one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock_in);
    sfr_rd <= 1'b0;
    @(posedge clock_in);
    #1 d = sfr_rdata;
    @(posedge clock_in);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd_reg(a, r);
    chk(nm, {4'h0, r}, {4'h0, exp});
  endtask

  // Write a byte and capture n line bits after the start
  task automatic txf(input logic [7:0] d, input int n, input logic [11:0] e);
    logic [11:0] got;
    fork
      wr_reg(ADDR_DATA, d);
      peer_u.grab(n, got);
    join
    chk("tx frame", got, e);
    repeat (8) @(posedge clock_in);
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rchk("mode", ADDR_MODE, 8'h0c);
    rchk("baud", ADDR_BAUD_CTRL, 8'h00);
    rchk("ctrl", ADDR_CTRL, 8'h20);
    rchk("reload hi", ADDR_RELOAD_HI, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    // Reload first: the timer only picks it up while stopped or on overflow
    wr_reg(ADDR_RELOAD_HI, 8'hff);
    wr_reg(ADDR_RELOAD_LO, 8'hfe);
    wr_reg(ADDR_BAUD_CTRL, 8'h43);
    rchk("baud", ADDR_BAUD_CTRL, 8'h43);
    rchk("reload hi", ADDR_RELOAD_HI, 8'hff);
    rchk("reload lo", ADDR_RELOAD_LO, 8'hfe);
    wr_reg(ADDR_CTRL, 8'h10);
    // Every length with every parity type
    for (int l = 0; l < 4; l++) begin
      for (int t = 0; t < 4; t++) begin
        m = 8'hb5 & ~(8'hff << (5 + l));
        p = (t == 0) ? ~^m : (t == 1) ? ^m : (t == 2);
        wr_reg(ADDR_MODE, {1'b0, t[1:0], 1'b1, l[1:0], 2'b00});
        txf(8'hb5, l + 7, {4'h0, m} | (12'(p) << (l + 5)) | (12'h001 << (l + 6)));
      end
    end
    wr_reg(ADDR_MODE, 8'h0e);
    wr_reg(ADDR_CTRL, 8'h18);
    txf(8'h3c, 10, 12'h33c);
    wr_reg(ADDR_MODE, 8'h0d);
    // A queued second byte would start inside a long stop's second bit if the stop were cut short
    fork
      begin
        wr_reg(ADDR_DATA, 8'hc3);
        wr_reg(ADDR_DATA, 8'h99);
      end
      peer_u.grab(10, g1);
    join
    chk("long stop", g1, 12'h3c3);
    repeat (60) @(posedge clock_in);
    wr_reg(ADDR_MODE, 8'h0c);
    // Second write lands once the first byte has left the holder
    fork
      begin
        wr_reg(ADDR_DATA, 8'h81);
        repeat (4) @(posedge clock_in);
        wr_reg(ADDR_DATA, 8'h7e);
      end
      begin
        peer_u.grab(9, g1);
        peer_u.grab(9, g2);
      end
    join
    chk("first", g1, 12'h181);
    chk("second", g2, 12'h17e);
    repeat (8) @(posedge clock_in);
    wr_reg(ADDR_CTRL, 8'h10);
    // Four bytes into a three-deep queue
    for (int i = 1; i < 5; i++) begin
      peer_u.send({3'h0, 8'(i * 8'h11)}, 8);
    end
    @(posedge clock_in);
    rchk("overrun", ADDR_CTRL, 8'hb5);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_CTRL, 8'h10);
      rchk("rx flag", ADDR_CTRL, 8'h34 | ((i < 2) ? 8'h01 : 8'h00));
      rchk("rx data", ADDR_DATA, 8'(8'h11 * (i + 1)));
    end
    wr_reg(ADDR_CTRL, 8'h10);
    wr_reg(ADDR_MODE, 8'h8e);
    peer_u.send({3'h0, 8'h5a}, 9);
    peer_u.send({3'h1, 8'ha6}, 9);
    @(posedge clock_in);
    rchk("filter", ADDR_CTRL, 8'h35);
    rchk("addr byte", ADDR_DATA, 8'ha6);
    wr_reg(ADDR_CTRL, 8'h10);
    // Filter stays off with parity on; wrong even parity
    wr_reg(ADDR_MODE, 8'hbe);
    peer_u.send({3'h0, 8'h01}, 9);
    @(posedge clock_in);
    rd_reg(ADDR_CTRL, v);
    chk("parity err", {4'h0, v & 8'hfb}, 12'h071);
    rchk("par data", ADDR_DATA, 8'h01);
    // Low stretch of a zero byte is start plus eight bits at each prescale
    wr_reg(ADDR_MODE, 8'h0c);
    wr_reg(ADDR_RELOAD_LO, 8'hff);
    for (int s = 0; s < 4; s++) begin
      dv = (s == 0) ? 12 : (s == 1) ? 4 : (s == 2) ? 48 : 1;
      wr_reg(ADDR_BAUD_CTRL, {6'h10, s[1:0]});
      repeat (100) @(posedge clock_in);
      wr_reg(ADDR_DATA, 8'h00);
      lowc = 0;
      repeat (20 * dv + 40) begin
        @(negedge clock_in);
        lowc += (line_tx == 1'b0);
      end
      chk("prescale", {11'h0, lowc >= 17 * dv && lowc <= 18 * dv + 1}, 12'h001);
      @(posedge clock_in);
    end
    // Stopped generator keeps the line idle
    wr_reg(ADDR_BAUD_CTRL, 8'h03);
    wr_reg(ADDR_DATA, 8'h00);
    lo = 1'b0;
    repeat (40) begin
      @(posedge clock_in);
      lo = lo | ~line_tx;
    end
    chk("stopped", {11'h0, lo}, 12'h000);
    stop_test();
  end
endmodule
